// file: verilog/chrpc_ctrl.sv
// How it works
// - both halters must release before leaving debug halt
// - acknowledge controller halt even when already debug-halted
// - run acknowledge only after running, status cleared
// - controller run during debugger operation keeps halt
// - debugger resume keeps halt while controller halt outstanding
// - four wake events end power firmware halt
// - only enabled highest-priority interrupt wakes a halted core
// - pending interrupts serviced once running again
// - dma accepted in both halted states
// - halt bit write starts quiesce then halt
// - halt bit reads zero, ignored in debug mode
// - reserved bits read zero, writes take any value
// - pause count loaded by write, reads zero
// - pause counts down, ends at zero or interrupt
// - pause keeps core in running state
// - power halt during pause freezes the countdown
// - pause length may skid a few cycles
// - wait-for-interrupt is a no-op, never stops core
// - run request and acknowledge follow full handshake
// - debug status high whenever core in debug mode
`timescale 1ns/1ps
module chrpc_ctrl (
    input wire logic sys_clk, // core clock, 50 MHz
    input wire logic rst_n, // synchronous reset, active low
    // csr access
    input wire logic csr_wr_en, // csr write strobe
    input wire logic csr_rd_en, // csr read strobe
    input wire logic [11:0] csr_addr, // csr address
    input wire logic [31:0] csr_wdata, // csr write data
    output logic [31:0] csr_rdata, // csr read data
    output logic csr_rd_valid, // read data valid pulse
    output logic csr_hit, // address is one of ours, registered
    // core debugger
    input wire logic dbg_halt_req, // debugger halt request
    input wire logic dbg_resume_req, // debugger resume request
    input wire logic dbg_busy, // debugger operation in progress
    // multi-core debug controller
    input wire logic mpc_reset_run_req, // start running out of reset
    input wire logic mpc_halt_req, // controller halt request
    output logic mpc_halt_ack, // controller halt acknowledge
    input wire logic mpc_run_req, // controller run request
    output logic mpc_run_ack, // controller run acknowledge
    output logic debug_mode_status, // core in debug mode
    // power management unit
    input wire logic pmu_halt_req, // power unit halt request
    input wire logic pmu_run_req, // power unit run request
    output logic core_halted, // core in power firmware halt
    // wake and interrupt sources
    input wire logic pic_wakeup, // highest-priority interrupt wake
    input wire logic mstatus_mie, // global machine interrupt enable
    input wire logic mie_meie, // external interrupt enable
    input wire logic timer_int, // timer interrupt
    input wire logic nmi_int, // non-maskable interrupt
    input wire logic ext_int_pending, // signalled external interrupt
    output logic ext_int_take, // take the external interrupt now
    // pipeline and dma
    input wire logic core_idle, // pipeline fully quiesced
    output logic exec_stall, // hold instruction execution
    input wire logic dma_req, // dma transfer request
    output logic dma_grant // dma transfer accepted
);
    // activity state and debug halt sources
    chrpc_pkg::chrpc_state_t state; // current activity state
    chrpc_pkg::chrpc_state_t next_state; // next activity state
    logic dbg_hold; // debugger halt outstanding
    logic mpc_hold; // controller halt outstanding
    logic next_dbg_hold; // next debugger hold
    logic next_mpc_hold; // next controller hold
    logic boot_seen; // first cycle after reset release passed
    logic [31:0] pause_count; // remaining pause cycles
    logic pause_active; // pause in progress

    // csr decode
    wire pause_sel = (csr_addr == chrpc_pkg::PAUSE_ADDR); // pause reg
    wire pmc_sel = (csr_addr == chrpc_pkg::PMC_ADDR); // halt control
    wire csr_sel = pause_sel || pmc_sel; // any of our registers
    wire pause_wr = csr_wr_en && pause_sel; // load pause count
    // halt bit write, dropped in debug mode
    wire fw_halt_wr = csr_wr_en && pmc_sel && !debug_mode_status
        && csr_wdata[chrpc_pkg::PMC_HALT_BIT];

    // state decodes
    wire running = (state == chrpc_pkg::ST_RUN); // running state
    wire pf_halt = (state == chrpc_pkg::ST_PF_HALT); // power halt
    wire debug_halted_state = (state == chrpc_pkg::ST_DEBUG_HALTED_STATE); // debug halt

    // debug halt entry and exit
    wire db_enter = dbg_hold || mpc_hold; // any halter outstanding
    wire db_exit = !dbg_hold && !mpc_hold && !dbg_busy;

    // wake from power firmware halt
    wire int_wake = pic_wakeup && mstatus_mie && mie_meie;
    wire wake_any = pmu_run_req || int_wake
        || timer_int || nmi_int;

    // handshake ready terms
    wire halt_ready = debug_mode_status;
    wire run_ready = running && !debug_mode_status;

    // any interrupt received ends a pause; halted, the count stays frozen
    wire any_int = (ext_int_pending || timer_int || nmi_int)
        && running;

    // debug mode status follows the state register
    assign debug_mode_status = debug_halted_state;
    assign core_halted = pf_halt;

    // dma is served in every state, halted ones included
    assign dma_grant = dma_req;

    // lower-priority interrupts wait until running again
    assign ext_int_take = ext_int_pending && running;

    // execution held by pause or any non-running state; wfi plays no
    // part here, so it retires as a plain no-op
    assign exec_stall = pause_active || !running;

    // halter bookkeeping: a new halt wins over a same-cycle release
    always_comb begin
        next_dbg_hold = dbg_hold;
        next_mpc_hold = mpc_hold;
        if (dbg_resume_req && !dbg_busy) begin
            next_dbg_hold = 1'b0; // debugger release
        end
        if (mpc_run_req) begin
            next_mpc_hold = 1'b0; // controller release
        end
        if (dbg_halt_req) begin
            next_dbg_hold = 1'b1; // debugger halt
        end
        if (mpc_halt_req) begin
            next_mpc_hold = 1'b1; // controller halt
        end
        if (!boot_seen && !mpc_reset_run_req) begin
            next_mpc_hold = 1'b1; // controller wants debug from reset
        end
    end

    // activity state transitions
    always_comb begin
        next_state = state;
        case (state)
            chrpc_pkg::ST_RUN: begin
                if (db_enter) begin
                    next_state = chrpc_pkg::ST_DEBUG_HALTED_STATE;
                end else if (fw_halt_wr || pmu_halt_req) begin
                    next_state = chrpc_pkg::ST_QUIESCE;
                end
            end
            chrpc_pkg::ST_QUIESCE: begin
                if (db_enter) begin
                    next_state = chrpc_pkg::ST_DEBUG_HALTED_STATE;
                end else if (core_idle) begin
                    next_state = chrpc_pkg::ST_PF_HALT;
                end
            end
            chrpc_pkg::ST_PF_HALT: begin
                if (db_enter) begin
                    next_state = chrpc_pkg::ST_DEBUG_HALTED_STATE;
                end else if (wake_any) begin
                    next_state = chrpc_pkg::ST_RUN;
                end
            end
            chrpc_pkg::ST_DEBUG_HALTED_STATE: begin
                if (db_exit) begin
                    next_state = chrpc_pkg::ST_RUN;
                end
            end
            default: begin
                next_state = chrpc_pkg::ST_RUN; // recover
            end
        endcase
    end

    // state and halter registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= chrpc_pkg::ST_RUN;
            dbg_hold <= 1'b0;
            mpc_hold <= 1'b0;
            boot_seen <= 1'b0;
        end else begin
            state <= next_state;
            dbg_hold <= next_dbg_hold;
            mpc_hold <= next_mpc_hold;
            boot_seen <= 1'b1; // strap caught once after release
        end
    end

    // csr read path: both registers read as zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            csr_rdata <= chrpc_pkg::CSR_READ_VAL;
            csr_rd_valid <= 1'b0;
            csr_hit <= 1'b0;
        end else begin
            csr_rdata <= chrpc_pkg::CSR_READ_VAL;
            csr_rd_valid <= csr_rd_en;
            csr_hit <= (csr_rd_en || csr_wr_en) && csr_sel;
        end
    end

    // controller halt handshake
    chrpc_hs_ack u_halt_hs (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .req(mpc_halt_req),
        .ready(halt_ready),
        .ack(mpc_halt_ack)
    );

    // controller run handshake
    chrpc_hs_ack u_run_hs (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .req(mpc_run_req),
        .ready(run_ready),
        .ack(mpc_run_ack)
    );

    // pause countdown, frozen outside running, length may skid
    chrpc_pause_ctr u_pause (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .load(pause_wr),
        .load_val(csr_wdata),
        .run_en(running),
        .abort(any_int),
        .count(pause_count),
        .active(pause_active)
    );

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // a firmware halt write taken while running
    sequence s_fw_halt;
        running && fw_halt_wr && !db_enter;
    endsequence

    // quiesce reached with no debug halt pending
    sequence s_drained;
        (state == chrpc_pkg::ST_QUIESCE) && core_idle && !db_enter;
    endsequence

    dual_exit_a: assert property (
        (dbg_hold || mpc_hold) && debug_mode_status
        |=> debug_mode_status)
        else $error("left debug halt with a halter outstanding");

    halt_ack_a: assert property (
        mpc_halt_req && debug_mode_status |=> mpc_halt_ack)
        else $error("controller halt not acknowledged while halted");

    run_ack_a: assert property (
        $rose(mpc_run_ack) |-> $past(run_ready))
        else $error("run acknowledged before running");

    busy_hold_a: assert property (
        debug_mode_status && dbg_busy |=> debug_mode_status)
        else $error("left debug halt during debugger operation");

    resume_hold_a: assert property (
        debug_mode_status && mpc_hold && !mpc_run_req
        |=> debug_mode_status [*2])
        else $error("left debug halt without controller run");

    wake_run_a: assert property (
        pf_halt && wake_any && !db_enter |=> running)
        else $error("wake event did not resume core");

    stay_halt_a: assert property (
        pf_halt && !wake_any && !db_enter |=> pf_halt)
        else $error("core woke without a wake event");

    int_run_a: assert property (
        ext_int_take |-> running && ext_int_pending)
        else $error("interrupt taken outside running state");

    dma_serve_a: assert property (
        dma_req |-> dma_grant)
        else $error("dma refused");

    fw_halt_a: assert property (
        s_fw_halt ##1 s_drained |=> core_halted)
        else $error("firmware halt did not reach halted state");

    quiesce_a: assert property (
        $rose(core_halted) |-> $past(core_idle))
        else $error("halted before quiesce");

    dbg_ignore_a: assert property (
        debug_mode_status && csr_wr_en && pmc_sel && !db_exit
        |=> debug_mode_status)
        else $error("halt write acted in debug mode");

    read_zero_a: assert property (
        csr_rd_valid |-> csr_rdata == chrpc_pkg::CSR_READ_VAL)
        else $error("csr read not zero");

    pause_dec_a: assert property (
        pause_active && running && !any_int && !pause_wr
        |=> pause_count == $past(pause_count) - 32'h0000_0001)
        else $error("pause count did not step down");

    pause_freeze_a: assert property (
        pause_active && !running && !any_int && !pause_wr
        |=> $stable(pause_count))
        else $error("pause count moved while halted");

    run_hold_a: assert property (
        mpc_run_ack && mpc_run_req |=> mpc_run_ack)
        else $error("run acknowledge dropped early");

    // each acknowledge falls the cycle after its request falls
    run_drop_a: assert property (
        !mpc_run_req |=> !mpc_run_ack)
        else $error("run acknowledge outlived its request");

    halt_drop_a: assert property (
        !mpc_halt_req |=> !mpc_halt_ack)
        else $error("halt acknowledge outlived its request");

    pause_int_a: assert property (
        any_int && !pause_wr |=> !pause_active)
        else $error("interrupt did not end the pause");

    pause_run_a: assert property (
        pause_wr && running && !db_enter && !fw_halt_wr && !pmu_halt_req
        |=> running)
        else $error("pause changed the activity state");

    masked_wake_a: assert property (
        pf_halt && pic_wakeup && !(mstatus_mie && mie_meie)
        && !pmu_run_req && !timer_int && !nmi_int && !db_enter
        |=> pf_halt)
        else $error("masked wake-up ended the halt");

    boot_halt_a: assert property (
        !boot_seen && !mpc_reset_run_req |-> ##2 debug_mode_status)
        else $error("debug halt strap not honoured");
endmodule : chrpc_ctrl

// file: verilog/chrpc_pkg.sv
package chrpc_pkg;
    // csr address space
    localparam int CSR_AW = 12; // csr address width
    localparam int CSR_DW = 32; // csr data width
    localparam logic [11:0] PAUSE_ADDR = 12'h7C2; // core pause count
    localparam logic [11:0] PMC_ADDR = 12'h7C6; // power halt control
    // power halt control field
    localparam int PMC_HALT_BIT = 0; // halt request bit, reads zero
    // reset and read values
    localparam logic [31:0] PAUSE_RESET = 32'h0000_0000; // pause count
    localparam logic [31:0] PMC_RESET = 32'h0000_0000; // halt control
    localparam logic [31:0] CSR_READ_VAL = 32'h0000_0000; // both read 0
    // countdown step per core clock
    localparam logic [31:0] PAUSE_STEP = 32'h0000_0001; // decrement
    // core activity states
    typedef enum logic [1:0] {
        ST_RUN,       // running
        ST_QUIESCE,   // draining toward power firmware halt
        ST_PF_HALT,   // power_firmware_halted_state
        ST_DEBUG_HALTED_STATE    // debug_halted_state
    } chrpc_state_t;
endpackage : chrpc_pkg

// file: verilog/chrpc_hs_ack.sv
`timescale 1ns/1ps
// acknowledge side of a full request/acknowledge handshake
module chrpc_hs_ack (
    input wire logic sys_clk, // core clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic req, // request level from the partner
    input wire logic ready, // condition for acknowledging
    output logic ack // acknowledge level
);
    // ack rises once ready, holds while req, drops after req drops
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ack <= 1'b0;
        end else if (!req) begin
            ack <= 1'b0; // partner dropped request
        end else if (ready) begin
            ack <= 1'b1; // held until request falls
        end
    end
endmodule : chrpc_hs_ack

// file: verilog/chrpc_pause_ctr.sv
`timescale 1ns/1ps
// pause countdown: loaded by a csr write, counts while running
module chrpc_pause_ctr (
    input wire logic sys_clk, // core clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic load, // csr write to the pause count
    input wire logic [31:0] load_val, // value written
    input wire logic run_en, // core in running state
    input wire logic abort, // any interrupt received
    output logic [31:0] count, // remaining pause cycles
    output logic active // pause in progress
);
    // load first, an interrupt ends the pause, else count down
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            count <= chrpc_pkg::PAUSE_RESET;
        end else if (load) begin
            count <= load_val;
        end else if (abort) begin
            count <= chrpc_pkg::PAUSE_RESET;
        end else if (run_en && active) begin
            count <= count - chrpc_pkg::PAUSE_STEP;
        end
    end

    // nonzero count means execution is held
    assign active = (count != chrpc_pkg::PAUSE_RESET);
endmodule : chrpc_pause_ctr

// file: bench/chrpc_mpc_model.sv
`timescale 1ns/1ps
// multi-core controller side of the halt and run handshakes
module chrpc_mpc_model (
    input wire logic sys_clk, // core clock
    input wire logic halt_cmd, // bench asks for a halt handshake
    input wire logic run_cmd, // bench asks for a run handshake
    input wire logic mpc_halt_ack, // halt acknowledge from the core
    input wire logic mpc_run_ack, // run acknowledge from the core
    output logic mpc_halt_req, // halt request to the core
    output logic mpc_run_req // run request to the core
);
    logic halt_pend; // halt asked for, no acknowledge yet
    logic run_pend; // run asked for, no acknowledge yet
    initial begin
        halt_pend = 1'b0;
        run_pend = 1'b0;
        mpc_halt_req = 1'b0;
        mpc_run_req = 1'b0;
    end
    // commands taken on the rising edge, dropped once ack is seen high
    always @(posedge sys_clk) begin
        if (halt_cmd) begin
            halt_pend <= 1'b1;
        end else if (mpc_halt_ack) begin
            halt_pend <= 1'b0;
        end
        if (run_cmd) begin
            run_pend <= 1'b1;
        end else if (mpc_run_ack) begin
            run_pend <= 1'b0;
        end
    end
    // requests move only on the falling edge, after ack was sampled
    always @(negedge sys_clk) begin
        mpc_halt_req <= halt_pend;
        mpc_run_req <= run_pend;
    end
endmodule : chrpc_mpc_model

// file: bench/tb_top.sv
`timescale 1ns/1ps
// register and handshake level tests of the activity-state control
module tb_top;
    logic sys_clk, rst_n, csr_wr_en, csr_rd_en, csr_rd_valid, csr_hit;
    logic [11:0] csr_addr; // csr address
    logic [31:0] csr_wdata, csr_rdata; // csr data
    logic dbg_halt_req, dbg_resume_req, dbg_busy, mpc_reset_run_req;
    logic mpc_halt_req, mpc_halt_ack, mpc_run_req, mpc_run_ack;
    logic debug_mode_status, pmu_halt_req, pmu_run_req, core_halted;
    logic pic_wakeup, mstatus_mie, mie_meie, timer_int, nmi_int;
    logic ext_int_pending, ext_int_take, core_idle, exec_stall;
    logic dma_req, dma_grant, halt_cmd, run_cmd;
    int miscompares, cmp_count, n; // counters and last wait length

    chrpc_ctrl i_chrpc_ctrl (
        .sys_clk(sys_clk), .rst_n(rst_n), .csr_wr_en(csr_wr_en),
        .csr_rd_en(csr_rd_en), .csr_addr(csr_addr), .csr_wdata(csr_wdata),
        .csr_rdata(csr_rdata), .csr_rd_valid(csr_rd_valid),
        .csr_hit(csr_hit), .dbg_halt_req(dbg_halt_req),
        .dbg_resume_req(dbg_resume_req), .dbg_busy(dbg_busy),
        .mpc_reset_run_req(mpc_reset_run_req), .mpc_halt_req(mpc_halt_req),
        .mpc_halt_ack(mpc_halt_ack), .mpc_run_req(mpc_run_req),
        .mpc_run_ack(mpc_run_ack), .debug_mode_status(debug_mode_status),
        .pmu_halt_req(pmu_halt_req), .pmu_run_req(pmu_run_req),
        .core_halted(core_halted), .pic_wakeup(pic_wakeup),
        .mstatus_mie(mstatus_mie), .mie_meie(mie_meie),
        .timer_int(timer_int), .nmi_int(nmi_int),
        .ext_int_pending(ext_int_pending), .ext_int_take(ext_int_take),
        .core_idle(core_idle), .exec_stall(exec_stall),
        .dma_req(dma_req), .dma_grant(dma_grant)
    );
    chrpc_mpc_model i_chrpc_mpc_model (
        .sys_clk(sys_clk), .halt_cmd(halt_cmd), .run_cmd(run_cmd),
        .mpc_halt_ack(mpc_halt_ack), .mpc_run_ack(mpc_run_ack),
        .mpc_halt_req(mpc_halt_req), .mpc_run_req(mpc_run_req)
    );

    // 50 MHz core clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // one comparison, counted, reported at once on mismatch
    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk);
    endtask : cyc
    // one-cycle pulse on a bench-driven line
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
    endtask : pulse
    // bounded wait for a level, cycles spent left in n
    task automatic wait_on(ref logic s, input logic v, input int lim,
                           input string m);
        n = 0;
        while (s !== v && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
        chk(s === v, m);
    endtask : wait_on
    task automatic csr_wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge sys_clk);
        csr_wr_en = 1'b1;
        csr_addr = a;
        csr_wdata = d;
        @(negedge sys_clk);
        csr_wr_en = 1'b0;
    endtask : csr_wr
    // read: data always zero, hit only for our two addresses
    task automatic csr_rd(input logic [11:0] a, input logic h);
        @(negedge sys_clk);
        csr_rd_en = 1'b1;
        csr_addr = a;
        @(negedge sys_clk);
        csr_rd_en = 1'b0;
        chk(csr_rd_valid === 1'b1 && csr_hit === h, "read answer");
        chk(csr_rdata === 32'h0000_0000, "read data");
    endtask : csr_rd
    // full controller halt handshake
    task automatic mpc_halt;
        pulse(halt_cmd);
        wait_on(mpc_halt_ack, 1'b1, 10, "halt ack");
        wait_on(mpc_halt_ack, 1'b0, 10, "halt ack drop");
    endtask : mpc_halt
    // run acknowledge only once running with status low
    task automatic mpc_run_end;
        wait_on(mpc_run_ack, 1'b1, 10, "run ack");
        chk(debug_mode_status === 1'b0, "status at run ack");
        chk(exec_stall === 1'b0, "running at run ack");
        wait_on(mpc_run_ack, 1'b0, 10, "run ack drop");
    endtask : mpc_run_end
    task automatic end_sim;
        $display("counts: %0d compares, %0d mismatches", cmp_count,
                 miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    // hang guard, the tests need well under 20 us
    initial begin
        #100us;
        miscompares++;
        $display("wrong value at %0t: watchdog expired", $time);
        end_sim();
    end

    // main sequence, inputs move on the falling edge
    initial begin
        {csr_wr_en, csr_rd_en, dbg_halt_req, dbg_resume_req} = 4'h0;
        {dbg_busy, pmu_halt_req, pmu_run_req, pic_wakeup} = 4'h0;
        {mstatus_mie, mie_meie, timer_int, nmi_int} = 4'h0;
        {ext_int_pending, core_idle, dma_req, halt_cmd, run_cmd} = 5'h00;
        csr_addr = 12'h000;
        csr_wdata = 32'h0000_0000;
        mpc_reset_run_req = 1'b1;
        rst_n = 1'b0;
        miscompares = 0;
        cmp_count = 0;
        cyc(12);
        rst_n = 1'b1;
        cyc(3);
        chk(debug_mode_status === 1'b0 && core_halted === 1'b0, "reset");
        csr_rd(chrpc_pkg::PAUSE_ADDR, 1'b1);
        csr_rd(chrpc_pkg::PMC_ADDR, 1'b1);
        csr_rd(12'h7C4, 1'b0);
        $display("test reset done");
        // debugger halt, controller halt, run while busy, resume
        pulse(dbg_halt_req);
        wait_on(debug_mode_status, 1'b1, 5, "debug halt");
        mpc_halt();
        dbg_busy = 1'b1;
        pulse(run_cmd);
        cyc(20);
        chk(debug_mode_status === 1'b1 && mpc_run_ack === 1'b0, "busy");
        dbg_busy = 1'b0;
        cyc(5);
        chk(debug_mode_status === 1'b1, "waits for resume");
        pulse(dbg_resume_req);
        mpc_run_end();
        $display("test debugger first done");
        // debugger resumes while controller halt is outstanding
        pulse(dbg_halt_req);
        mpc_halt();
        dma_req = 1'b1;
        cyc(1);
        chk(dma_grant === 1'b1, "dma in debug halt");
        dma_req = 1'b0;
        pulse(dbg_resume_req);
        cyc(10);
        chk(debug_mode_status === 1'b1, "resume alone");
        pulse(run_cmd);
        mpc_run_end();
        $display("test resume first done");
        // controller halt first, halt bit written in debug mode
        mpc_halt();
        pulse(dbg_halt_req);
        csr_wr(chrpc_pkg::PMC_ADDR, 32'h0000_0001);
        pulse(run_cmd);
        cyc(10);
        chk(debug_mode_status === 1'b1, "run alone");
        pulse(dbg_resume_req);
        mpc_run_end();
        cyc(5);
        chk(core_halted === 1'b0 && exec_stall === 1'b0, "write ign");
        $display("test controller first done");
        // firmware halt waits for quiesce, only enabled wake works
        csr_wr(chrpc_pkg::PMC_ADDR, 32'hFFFF_FFFF);
        cyc(5);
        chk(core_halted === 1'b0 && exec_stall === 1'b1, "quiesce");
        dma_req = 1'b1;
        core_idle = 1'b1;
        wait_on(core_halted, 1'b1, 3, "fw halt");
        chk(dma_grant === 1'b1, "dma in halt");
        csr_rd(chrpc_pkg::PMC_ADDR, 1'b1);
        {ext_int_pending, mie_meie, pic_wakeup} = 3'h7;
        cyc(5);
        chk(core_halted === 1'b1 && ext_int_take === 1'b0, "masked");
        mstatus_mie = 1'b1;
        wait_on(core_halted, 1'b0, 3, "wake on interrupt");
        chk(ext_int_take === 1'b1, "pending taken");
        {ext_int_pending, pic_wakeup, dma_req} = 3'h0;
        // remaining wake events: power run, timer, nmi
        for (int e = 0; e < 3; e++) begin
            csr_wr(chrpc_pkg::PMC_ADDR, 32'h0000_0001);
            wait_on(core_halted, 1'b1, 5, "halt again");
            {nmi_int, timer_int, pmu_run_req} = 3'(1 << e);
            wait_on(core_halted, 1'b0, 3, "wake event");
            {nmi_int, timer_int, pmu_run_req} = 3'h0;
        end
        $display("test halt and wake done");
        // pause: counted, running, read zero, cut by interrupt
        csr_wr(chrpc_pkg::PAUSE_ADDR, 32'h0000_0014);
        chk(exec_stall === 1'b1 && core_halted === 1'b0, "paused");
        wait_on(exec_stall, 1'b0, 40, "pause end");
        chk(n >= 16 && n <= 24, "pause length");
        csr_wr(chrpc_pkg::PAUSE_ADDR, 32'h0000_03E8);
        csr_rd(chrpc_pkg::PAUSE_ADDR, 1'b1);
        pulse(timer_int);
        wait_on(exec_stall, 1'b0, 5, "pause cut");
        // power halt in mid-pause freezes the countdown
        csr_wr(chrpc_pkg::PAUSE_ADDR, 32'h0000_0028);
        cyc(10);
        pulse(pmu_halt_req);
        wait_on(core_halted, 1'b1, 5, "halt in pause");
        cyc(100);
        pulse(pmu_run_req);
        wait_on(core_halted, 1'b0, 3, "wake from pause");
        wait_on(exec_stall, 1'b0, 60, "pause resumed");
        chk(n >= 22 && n <= 34, "frozen count");
        $display("test pause done");
        // second reset, strap asks for debug halt out of reset
        mpc_reset_run_req = 1'b0;
        rst_n = 1'b0;
        cyc(3);
        chk(mpc_run_ack === 1'b0 && exec_stall === 1'b0, "mid reset");
        rst_n = 1'b1;
        wait_on(debug_mode_status, 1'b1, 4, "boot halt");
        mpc_reset_run_req = 1'b1;
        pulse(run_cmd);
        mpc_run_end();
        $display("test boot halt done");
        end_sim();
    end
endmodule : tb_top
